/* rtl/sofm_defs.svh */
// constants of the safe-off input monitor: bus offsets, fields, timing
// assumes inclusion by bare name from the rtl folder
//
// What this block does
// R1 - sample both channels and supply each tick
// R2 - long channel mismatch raises an error
// R3 - request while switching active flags error
// R4 - request disables control and switching
// R5 - request drops brake only if configured
// R6 - one acknowledge clears all group errors
// R7 - safe-off circuit errors recorded by machine
// R8 - detect driver supply lost without a circuit request
// R9 - report status and errors on outputs
// R10 - enable removal decelerates the drive first
// R11 - wait brake engaged, then loop off
// R12 - relay drops enable first, requests later
// R13 - relay delay covers full quick stop
// R14 - no cross-circuit checking on request inputs
// R15 - discrepancy window defaults to 100 ms
// R16 - safe-off when both low within window
// R17 - count mismatch ticks beyond window over tick
`ifndef SOFM_DEFS_SVH
`define SOFM_DEFS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SOFM_CLK_HZ        125000000
`define SOFM_TICK_MS       10
`define SOFM_TICK_CYC      ((`SOFM_CLK_HZ / 1000) * `SOFM_TICK_MS)
`define SOFM_DISC_MS       100

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define SOFM_REG_CTRL      8'h00
`define SOFM_REG_STATUS    8'h04
`define SOFM_REG_ERR       8'h08
`define SOFM_REG_DISC      8'h0c

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define SOFM_CTRL_BRAKE_CFG 0
`define SOFM_CTRL_ACK       1
`define SOFM_CTRL_RESET     32'h0000_0000
`define SOFM_DISC_RESET     16'h0064

`endif

/* rtl/sofm_pkg.sv */
// types of the safe-off input monitor
// assumes nothing beyond the compiler
package sofm_pkg;

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		SOFM_RUN     = 5'b00001,
		SOFM_DECEL   = 5'b00010,
		SOFM_BRAKEW  = 5'b00100,
		SOFM_OFF     = 5'b01000,
		SOFM_SAFE    = 5'b10000
	} sofm_state_t;

	// ---------------------------------------------------------------
	// error flags
	// ---------------------------------------------------------------
	typedef struct packed {
		logic supply_lost;
		logic req_while_pwm;
		logic discrepancy;
	} sofm_err_t;

	// ---------------------------------------------------------------
	// drive-side commands
	// ---------------------------------------------------------------
	typedef struct packed {
		logic pwm_enable;
		logic control_enable;
		logic brake_release;
		logic decelerate;
	} sofm_drive_t;

endpackage

/* rtl/sofm_monitor.sv */
// safe-off input monitor: tick sampler, discrepancy check, stop sequence
// assumes raw pins from outside, drive feedback on CLK_SYS, wishbone master
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "sofm_defs.svh"

module sofm_monitor #(
	parameter int TICK_CYC = `SOFM_TICK_CYC,
	parameter int TICK_MS  = `SOFM_TICK_MS
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic        SAFE_OFF_REQUEST_A,
	input  wire logic        SAFE_OFF_REQUEST_B,
	input  wire logic        DRIVE_ENABLE_INPUT,
	input  wire logic        DRIVER_SUPPLY_OK,
	input  wire logic        PWM_ACTIVE,
	input  wire logic        SPEED_ZERO,
	input  wire logic        BRAKE_ENGAGED,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             PWM_ENABLE,
	output logic             CONTROL_ENABLE,
	output logic             BRAKE_RELEASE,
	output logic             DECELERATE,
	output logic             SAFE_TORQUE_OFF,
	output logic             ERROR_OUT
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			pin_s1_q <= 4'hf;
			pin_s2_q <= 4'hf;
		end else begin
			pin_s1_q <= {DRIVER_SUPPLY_OK, DRIVE_ENABLE_INPUT,
				SAFE_OFF_REQUEST_B, SAFE_OFF_REQUEST_A};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// tick generator
	// ---------------------------------------------------------------
	logic [23:0] tick_cnt_q, tick_cnt_d;
	logic        tick;
	always_comb begin
		tick = (tick_cnt_q == 24'(TICK_CYC - 1));
		tick_cnt_d = tick ? 24'h000000 : tick_cnt_q + 24'h000001;
	end
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET)
			tick_cnt_q <= 24'h000000;
		else
			tick_cnt_q <= tick_cnt_d;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic [15:0] disc_ms_q, disc_ms_d;
	logic [31:0] rdat_q, rdat_d;
	logic        ack_q, ack_d;
	logic        ack_pulse;
	logic        brake_cfg;
	logic        wr;

	sofm_pkg::sofm_err_t   err_q, err_d;
	sofm_pkg::sofm_state_t st_q, st_d;
	sofm_pkg::sofm_drive_t drv_q, drv_d;

	// per-byte write merge
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	assign brake_cfg = ctrl_q[`SOFM_CTRL_BRAKE_CFG];

	always_comb begin
		wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
		ack_d = WB_CYC_I && WB_STB_I && !ack_q;
		ctrl_d = ctrl_q;
		disc_ms_d = disc_ms_q;
		ack_pulse = 1'b0;
		rdat_d = 32'h0000_0000;
		if (wr && WB_ADR_I == `SOFM_REG_CTRL) begin
			ctrl_d = merge(ctrl_q, WB_DAT_I, WB_SEL_I) & 32'h0000_0001;
			ack_pulse = WB_SEL_I[0] && WB_DAT_I[`SOFM_CTRL_ACK];
		end
		if (wr && WB_ADR_I == `SOFM_REG_DISC)
			disc_ms_d = 16'(merge({16'h0000, disc_ms_q}, WB_DAT_I,
				WB_SEL_I));
		unique case (WB_ADR_I)
			`SOFM_REG_CTRL:   rdat_d = ctrl_q;
			`SOFM_REG_STATUS: rdat_d = {21'h000000, st_q, drv_q,
				pin_s2_q[1:0]};
			`SOFM_REG_ERR:    rdat_d = {29'h00000000, err_q};
			`SOFM_REG_DISC:   rdat_d = {16'h0000, disc_ms_q};
			default:          rdat_d = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// tick sampler and discrepancy counter
	// ---------------------------------------------------------------
	logic        req_a_q, req_b_q, en_q, sup_q;
	logic [15:0] mis_cnt_q, mis_cnt_d;
	logic        req_both;
	logic        disc_hit;
	always_comb begin
		mis_cnt_d = mis_cnt_q;
		// channels read independently, no cross-circuit test [R14]
		if (tick) begin
			if (pin_s2_q[0] != pin_s2_q[1])
				mis_cnt_d = (mis_cnt_q == 16'hffff) ? mis_cnt_q
					: mis_cnt_q + 16'h0001; // [R17]
			else
				mis_cnt_d = 16'h0000;
		end
		// window in ticks, default 100 ms [R15]
		disc_hit = tick && (pin_s2_q[0] != pin_s2_q[1]) &&
			(mis_cnt_q >= 16'(disc_ms_q / 16'(TICK_MS))); // [R2] [R17]
		req_both = !req_a_q && !req_b_q; // [R16]
	end
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			req_a_q <= 1'b1;
			req_b_q <= 1'b1;
			en_q <= 1'b0;
			sup_q <= 1'b1;
			mis_cnt_q <= 16'h0000;
		end else begin
			if (tick) begin // [R1]
				req_a_q <= pin_s2_q[0];
				req_b_q <= pin_s2_q[1];
				en_q <= pin_s2_q[2];
				sup_q <= pin_s2_q[3];
			end
			mis_cnt_q <= mis_cnt_d;
		end
	end

	// ---------------------------------------------------------------
	// stop sequence and errors
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		err_d = err_q;
		// set wins over the group acknowledge [R6] [R7]
		if (ack_pulse)
			err_d = '0;
		if (disc_hit)
			err_d.discrepancy = 1'b1; // [R2] [R7]
		// fresh pin sample: the state has not yet reached safe here
		if (tick && !pin_s2_q[0] && !pin_s2_q[1] && PWM_ACTIVE &&
				st_q != sofm_pkg::SOFM_SAFE)
			err_d.req_while_pwm = 1'b1; // [R3]
		if (tick && !sup_q && !req_both)
			err_d.supply_lost = 1'b1; // [R8]
		unique case (st_q)
			sofm_pkg::SOFM_RUN:
				if (req_both)
					st_d = sofm_pkg::SOFM_SAFE;
				else if (!en_q)
					st_d = sofm_pkg::SOFM_DECEL; // [R10]
			sofm_pkg::SOFM_DECEL:
				if (req_both)
					st_d = sofm_pkg::SOFM_SAFE;
				else if (SPEED_ZERO)
					st_d = brake_cfg ? sofm_pkg::SOFM_BRAKEW
						: sofm_pkg::SOFM_OFF;
			sofm_pkg::SOFM_BRAKEW:
				if (req_both)
					st_d = sofm_pkg::SOFM_SAFE;
				else if (BRAKE_ENGAGED)
					st_d = sofm_pkg::SOFM_OFF; // [R11]
			sofm_pkg::SOFM_OFF:
				if (req_both)
					st_d = sofm_pkg::SOFM_SAFE;
				else if (en_q)
					st_d = sofm_pkg::SOFM_RUN;
			sofm_pkg::SOFM_SAFE:
				if (req_a_q && req_b_q && !en_q)
					st_d = sofm_pkg::SOFM_OFF;
			default:
				st_d = sofm_pkg::SOFM_SAFE;
		endcase
		drv_d.decelerate = (st_d == sofm_pkg::SOFM_DECEL); // [R10]
		drv_d.pwm_enable = (st_d == sofm_pkg::SOFM_RUN) ||
			(st_d == sofm_pkg::SOFM_DECEL) ||
			(st_d == sofm_pkg::SOFM_BRAKEW); // [R4] [R11]
		drv_d.control_enable = drv_d.pwm_enable; // [R4]
		// unconfigured brake output stays released [R5]
		drv_d.brake_release = !brake_cfg ||
			(st_d == sofm_pkg::SOFM_RUN) ||
			(st_d == sofm_pkg::SOFM_DECEL);
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ctrl_q <= `SOFM_CTRL_RESET;
			disc_ms_q <= `SOFM_DISC_RESET;
			rdat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			err_q <= '0;
			st_q <= sofm_pkg::SOFM_OFF;
			drv_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			disc_ms_q <= disc_ms_d;
			rdat_q <= rdat_d;
			ack_q <= ack_d;
			err_q <= err_d;
			st_q <= st_d;
			drv_q <= drv_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	logic sto_q, errout_q;
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			sto_q <= 1'b0;
			errout_q <= 1'b0;
		end else begin
			sto_q <= (st_d == sofm_pkg::SOFM_SAFE); // [R9]
			errout_q <= |err_d; // [R9]
		end
	end

	assign WB_DAT_O = rdat_q;
	assign WB_ACK_O = ack_q;
	assign PWM_ENABLE = drv_q.pwm_enable;
	assign CONTROL_ENABLE = drv_q.control_enable;
	assign BRAKE_RELEASE = drv_q.brake_release;
	assign DECELERATE = drv_q.decelerate;
	assign SAFE_TORQUE_OFF = sto_q;
	assign ERROR_OUT = errout_q;

endmodule

/* dv/sofm_relay.sv */
// partner: safety relay on the request pins, enable and driver supply
// assumes one caller at a time and a clock from the bench
module sofm_relay (
	input  wire logic clk,
	output logic      req_a,
	output logic      req_b,
	output logic      en,
	output logic      sup
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_a = 1'b1;
		req_b = 1'b1;
		en = 1'b0;
		sup = 1'b1;
	end
	// supply cut by the safe circuit, or forced off
	task automatic set(input logic a, b, e, s, input int n);
		@(posedge clk);
		req_a <= a;
		req_b <= b;
		en <= e;
		sup <= s & (a | b);
		repeat (n) @(posedge clk);
	endtask
	task automatic ss1(input int dly);
		set(1'b1, 1'b1, 1'b0, 1'b1, dly);
		set(1'b0, 1'b0, 1'b0, 1'b1, 0);
	endtask
endmodule

/* dv/sofm_monitor_sva.sv */
// port checker of the safe-off monitor, bound into the design
// assumes the default window and a short tick parameter
module sofm_monitor_sva #(
	parameter int TICK_CYC = 10
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic SAFE_OFF_REQUEST_A,
	input wire logic SAFE_OFF_REQUEST_B,
	input wire logic DRIVE_ENABLE_INPUT,
	input wire logic PWM_ACTIVE,
	input wire logic WB_CYC_I,
	input wire logic WB_WE_I,
	input wire logic WB_ACK_O,
	input wire logic PWM_ENABLE,
	input wire logic CONTROL_ENABLE,
	input wire logic DECELERATE,
	input wire logic SAFE_TORQUE_OFF,
	input wire logic ERROR_OUT
);
	logic [31:0] lo_q, lo_d, mm_q, mm_d;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	// cycles both low, cycles mismatched
	always_comb begin
		lo_d = (SAFE_OFF_REQUEST_A | SAFE_OFF_REQUEST_B) ? '0 : lo_q + 1;
		mm_d = (SAFE_OFF_REQUEST_A ^ SAFE_OFF_REQUEST_B) ? mm_q + 1 : '0;
	end
	always_ff @(posedge CLK_SYS or posedge RESET)
		if (RESET) {lo_q, mm_q} <= '0;
		else {lo_q, mm_q} <= {lo_d, mm_d};
	AST_OFF_GATES: assert property (
		SAFE_TORQUE_OFF |-> !PWM_ENABLE && !CONTROL_ENABLE)
		else $error("drive on in safe state");
	AST_BOTH_LOW: assert property (
		lo_q == 3 * TICK_CYC |-> SAFE_TORQUE_OFF)
		else $error("no safe state after both low");
	AST_WINDOW: assert property (
		mm_q == 13 * TICK_CYC |-> ERROR_OUT)
		else $error("no error after long mismatch");
	AST_DECEL: assert property (
		$fell(DRIVE_ENABLE_INPUT) && CONTROL_ENABLE && !SAFE_TORQUE_OFF
		|-> ##[1:30] DECELERATE)
		else $error("no deceleration on enable loss");
	AST_REQ_PWM: assert property (
		PWM_ACTIVE && $rose(SAFE_TORQUE_OFF) |-> ##[0:12] ERROR_OUT)
		else $error("no error on request while switching");
	AST_ERR_CLEAR: assert property (
		$fell(ERROR_OUT) |-> $past(WB_CYC_I && WB_WE_I)
		|| $past(WB_CYC_I && WB_WE_I, 2))
		else $error("error cleared without write");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I))
		else $error("ack without request");
endmodule
bind sofm_monitor sofm_monitor_sva #(.TICK_CYC(TICK_CYC)) u_sva (
	.CLK_SYS, .RESET, .SAFE_OFF_REQUEST_A, .SAFE_OFF_REQUEST_B,
	.DRIVE_ENABLE_INPUT, .PWM_ACTIVE, .WB_CYC_I, .WB_WE_I, .WB_ACK_O,
	.PWM_ENABLE, .CONTROL_ENABLE, .DECELERATE, .SAFE_TORQUE_OFF,
	.ERROR_OUT);

/* dv/tb_safe_off_input_monitor.sv */
// self-checking bench of the safe-off monitor with a relay partner
// assumes a ten cycle tick and the default discrepancy window
module tb_safe_off_input_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, pwm = 1'b0, spd = 1'b0;
	logic        brk = 1'b0, cyc = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wd = 32'h0, seed = 32'h5a7e6679, rd, dat;
	logic        ra, rb, en, sup, ack, pe, ce, br, dc, safe_torque_off, er;
	int          miscompares = 0, comparisons = 0, ncyc = 0;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		ncyc++;
		if (ncyc == 5000) begin
			miscompares++;
			test_done();
		end
	end
	sofm_relay u_sofm_relay (.clk(clk), .req_a(ra), .req_b(rb), .en(en),
		.sup(sup));
	sofm_monitor #(.TICK_CYC(10)) u_sofm_monitor (.CLK_SYS(clk),
		.RESET(rst), .SAFE_OFF_REQUEST_A(ra), .SAFE_OFF_REQUEST_B(rb),
		.DRIVE_ENABLE_INPUT(en), .DRIVER_SUPPLY_OK(sup),
		.PWM_ACTIVE(pwm), .SPEED_ZERO(spd), .BRAKE_ENGAGED(brk),
		.WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(dat), .WB_ACK_O(ack),
		.PWM_ENABLE(pe), .CONTROL_ENABLE(ce), .BRAKE_RELEASE(br),
		.DECELERATE(dc), .SAFE_TORQUE_OFF(safe_torque_off), .ERROR_OUT(er));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] errv(input logic d, p, s);
		return {29'h0, s, p, d};
	endfunction
	task automatic chk(input string n, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		// ack and read data taken at the rising edge that sees ack
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
			input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic test_done();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		logic x;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl", 8'h00, 32'h0);
		rdc("disc", 8'h0c, 32'h64);
		rdc("unmapped", 8'h10, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		rdc("ctrl", 8'h00, 32'h1);
		u_sofm_relay.set(1'b1, 1'b1, 1'b1, 1'b1, 40);
		settle(1);
		chk("run", {safe_torque_off, ce}, 2'b01);
		$display("registers and run done");
		fork
			u_sofm_relay.ss1(150 + int'(rnd() % 64));
			begin
				settle(40);
				chk("decel", dc, 1'b1);
				@(posedge clk) spd <= 1'b1;
				settle(40);
				chk("loop held", ce, 1'b1);
				@(posedge clk) brk <= 1'b1;
				settle(40);
				chk("loop off", ce, 1'b0);
			end
		join
		settle(40);
		chk("safe", {safe_torque_off, pe, br, er}, 4'b1000);
		rdc("status", 8'h04, 32'h0000_0400);
		$display("stop sequence done");
		@(posedge clk) begin
			spd <= 1'b0;
			brk <= 1'b0;
			pwm <= 1'b1;
		end
		u_sofm_relay.set(1'b1, 1'b1, 1'b0, 1'b1, 40);
		u_sofm_relay.set(1'b1, 1'b1, 1'b1, 1'b1, 40);
		u_sofm_relay.set(1'b0, 1'b0, 1'b1, 1'b1, 40);
		settle(1);
		chk("switching", {safe_torque_off, er}, 2'b11);
		@(posedge clk) pwm <= 1'b0;
		u_sofm_relay.set(1'b1, 1'b1, 1'b0, 1'b1, 40);
		fork
			u_sofm_relay.set(1'b0, 1'b1, 1'b0, 1'b1, 200);
			begin
				settle(150);
				rdc("window", 8'h08, errv(1'b1, 1'b1, 1'b0));
			end
		join
		u_sofm_relay.set(1'b1, 1'b1, 1'b0, 1'b1, 40);
		wb(1'b1, 8'h00, 32'h3);
		rdc("ack all", 8'h08, 32'h0);
		chk("ack out", er, 1'b0);
		$display("errors and acknowledge done");
		for (int i = 0; i < 4; i++) begin
			x = 1'(rnd() % 2);
			u_sofm_relay.set(x, !x, 1'b0, 1'b1, 1 + int'(rnd() % 30));
			u_sofm_relay.set(1'b1, 1'b1, 1'b0, 1'b1, 20);
		end
		chk("short", er, 1'b0);
		u_sofm_relay.set(1'b1, 1'b1, 1'b0, 1'b0, 60);
		rdc("supply", 8'h08, errv(1'b0, 1'b0, 1'b1));
		$display("pulses and supply done");
		test_done();
	end
endmodule
